// >>> tdm_rx_pkg.sv
// Constants, types and register map of the frame-mode audio input receiver
package tdm_rx_pkg;
    // APB register byte offsets
    localparam int APB_AW = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_BITS = 12'h008;
    localparam logic [11:0] ADDR_MEAS = 12'h00C;
    // Frame mode codes
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_128 = 2'h1;
    localparam logic [1:0] MODE_256 = 2'h2;
    localparam logic [1:0] MODE_512 = 2'h3;
    // Data format codes
    localparam logic [2:0] FMT_MSB24 = 3'h2;
    localparam logic [2:0] FMT_I2S24 = 3'h3;
    localparam logic [2:0] FMT_LSB24 = 3'h4;
    localparam logic [2:0] FMT_LSB32 = 3'h5;
    localparam logic [2:0] FMT_MSB32 = 3'h6;
    localparam logic [2:0] FMT_I2S32 = 3'h7;
    // Speed range codes that allow high-performance mode
    localparam logic [2:0] SPEED_001 = 3'h1;
    localparam logic [2:0] SPEED_010 = 3'h2;
    // Bit counts per frame and per slot
    localparam logic [10:0] FRAME_BITS_256 = 11'h100;
    localparam logic [10:0] FRAME_BITS_512 = 11'h200;
    localparam logic [10:0] HP_BITS_BASE = 11'h040;
    localparam logic [10:0] BIT_SAT = 11'h400;
    localparam logic [10:0] BIT_PRE = 11'h7FF;
    localparam logic [4:0] SLOT_LAST = 5'h1F;
    // Master clock periods per frame at 12.288 MHz
    localparam logic [10:0] MCK_PER_48 = 11'h100;
    localparam logic [10:0] MCK_PER_96 = 11'h080;
    // Frame periods and allowed deviation, in system clock cycles
    localparam int CLK_NS = 10;
    localparam int FRAME48_NS = 20833;
    localparam int FRAME96_NS = 10417;
    localparam logic [15:0] FRAME48_CYC = 16'(FRAME48_NS / CLK_NS);
    localparam logic [15:0] FRAME96_CYC = 16'(FRAME96_NS / CLK_NS);
    localparam logic [15:0] FRAME_TOL_CYC = 16'h0015;
    localparam logic [15:0] PERIOD_SAT = 16'hFFFF;
    // Reset values
    localparam logic [10:0] CTRL_RESET = 11'h000;
    // Receiver lock state
    typedef enum logic [1:0] {SYNC_HUNT = 2'b01, SYNC_RUN = 2'b10} syncState_e;
    // Control word: bits [1:0] mode, [4:2] format, [7:5] rotation, [10:8] speed
    typedef struct packed {
        logic [2:0] speed;
        logic [2:0] rot;
        logic [2:0] fmt;
        logic [1:0] mode;
    } ctrl_s;
    // One stereo DAC sample pair, left aligned 32-bit two's complement
    typedef struct packed {
        logic [31:0] left;
        logic [31:0] right;
    } dacPair_s;
endpackage

// >>> tdm_audio_rx.sv
// Frame-mode serial audio receiver with slot rotation onto four stereo DACs
`timescale 1ns/10ps
module tdm_audio_rx (
    // System
    input wire logic mclk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tdm_rx_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial audio pins
    input wire logic serialBitClock,
    input wire logic frameSyncClock,
    input wire logic [3:0] serialDataInput,
    input wire logic audioMasterClock,
    // DAC side
    output tdm_rx_pkg::dacPair_s [3:0] dacOut,
    output logic sampleStrobe,
    output logic highPerfMode
);
    import tdm_rx_pkg::*;

    // Pin synchroniser: meta stage, sync stage, history for edges
    logic [4:0] pinMeta_ff;
    logic [4:0] pinSync_ff;
    logic [4:0] pinPrev_ff;
    logic bclkRise; // One-cycle pulse per bit clock rise
    logic mckRise; // One-cycle pulse per master clock rise
    logic lrLast_ff; // Frame clock as seen at previous bit clock rise
    // Control and measured state
    ctrl_s ctrl_ff;
    syncState_e syncState_ff;
    logic [10:0] bitCnt_ff; // Index of the last bit taken in the frame
    logic [10:0] seqIdx; // Index of the bit taken now
    logic [10:0] frameLen;
    logic [10:0] frameBits_ff;
    logic [10:0] mckCnt_ff;
    logic [10:0] mckPerFrame_ff;
    logic [15:0] periodCnt_ff;
    logic [15:0] period_ff;
    logic ratioOk_ff;
    logic edgeDly_ff; // Frame edge, delayed so the last I2S slot lands first
    // Serial shifters and slot store
    logic [31:0] shiftA_ff;
    logic [31:0] shiftB_ff;
    logic [31:0] wordA;
    logic [31:0] wordB;
    logic [31:0] slotMem [16];
    logic isFrameMode;
    logic isI2s;
    logic silent;
    logic frameEdge;
    logic slotDone;
    logic [3:0] slotNum;
    logic addrMapped;
    wire dacPair_s [3:0] nxt_dacOut;

    // Bring pins into the mclk domain; only the sync stage and its history are used, as levels and edges
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pinMeta_ff <= 5'h00;
            pinSync_ff <= 5'h00;
            pinPrev_ff <= 5'h00;
        end else begin
            // Inputs 3 and 4 carry nothing in frame modes, so never sampled
            pinMeta_ff <= {audioMasterClock, serialDataInput[1:0], frameSyncClock,
                serialBitClock};
            pinSync_ff <= pinMeta_ff;
            pinPrev_ff <= pinSync_ff;
        end
    end

    assign bclkRise = pinSync_ff[0] & ~pinPrev_ff[0];
    assign mckRise = pinSync_ff[4] & ~pinPrev_ff[4];
    assign isFrameMode = ctrl_ff.mode[1];
    assign isI2s = (ctrl_ff.fmt == FMT_I2S24) || (ctrl_ff.fmt == FMT_I2S32);
    // Codes 000 and 001 are not decoded in frame modes
    assign silent = !isFrameMode || (ctrl_ff.fmt[2:1] == 2'b00);
    assign frameLen = (ctrl_ff.mode == MODE_512) ? FRAME_BITS_512 : FRAME_BITS_256;
    // I2S frames open on a falling frame clock, all others on a rising one
    assign frameEdge = bclkRise && (isI2s ? (lrLast_ff && !pinSync_ff[1])
        : (!lrLast_ff && pinSync_ff[1]));
    // Saturate so an absent frame edge cannot wrap into a valid slot
    assign seqIdx = (bitCnt_ff == BIT_SAT) ? BIT_SAT : bitCnt_ff + 11'h001;
    // A slot closes on its 32nd bit; bits past the frame length are dropped
    assign slotDone = bclkRise && isFrameMode && (syncState_ff == SYNC_RUN)
        && (seqIdx[4:0] == SLOT_LAST) && (seqIdx < frameLen);
    assign slotNum = seqIdx[8:5];
    assign wordA = {shiftA_ff[30:0], pinSync_ff[2]};
    assign wordB = {shiftB_ff[30:0], pinSync_ff[3]};
    // Last frame clock level, taken at each bit clock rise
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lrLast_ff <= 1'b0;
        end else if (bclkRise) begin
            lrLast_ff <= pinSync_ff[1];
        end
    end
    // Lock: hunt for the first frame edge, drop lock outside frame modes
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            syncState_ff <= SYNC_HUNT;
        end else begin
            case (syncState_ff)
                SYNC_HUNT: begin
                    if (isFrameMode && frameEdge) begin
                        syncState_ff <= SYNC_RUN;
                    end
                end
                SYNC_RUN: begin
                    if (!isFrameMode) begin
                        syncState_ff <= SYNC_HUNT;
                    end
                end
                default: syncState_ff <= SYNC_HUNT;
            endcase
        end
    end
    // Bit position: I2S data lags the frame edge by one bit clock
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bitCnt_ff <= BIT_SAT;
        end else if (frameEdge) begin
            bitCnt_ff <= isI2s ? BIT_PRE : 11'h000;
        end else if (bclkRise) begin
            bitCnt_ff <= seqIdx;
        end
    end
    // MSB-first shifters, one per used data line
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            shiftA_ff <= 32'h0000_0000;
            shiftB_ff <= 32'h0000_0000;
        end else if (bclkRise) begin
            shiftA_ff <= wordA;
            shiftB_ff <= wordB;
        end
    end
    // Slot store; no reset since every slot is rewritten each frame
    always_ff @(posedge mclk) begin
        if (slotDone) begin
            if (ctrl_ff.mode == MODE_512) begin
                slotMem[slotNum] <= wordA;
            end else begin
                slotMem[{1'b0, slotNum[2:0]}] <= wordA;
                slotMem[{1'b1, slotNum[2:0]}] <= wordB;
            end
        end
    end
    // Per-frame measurements of bit clock, master clock and frame period
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            frameBits_ff <= 11'h000;
            mckCnt_ff <= 11'h000;
            mckPerFrame_ff <= 11'h000;
            periodCnt_ff <= 16'h0000;
            period_ff <= 16'h0000;
            ratioOk_ff <= 1'b0;
        end else if (frameEdge) begin
            mckCnt_ff <= mckRise ? 11'h001 : 11'h000;
            periodCnt_ff <= 16'h0001;
            if (syncState_ff == SYNC_RUN) begin
                frameBits_ff <= seqIdx + 11'(isI2s);
                mckPerFrame_ff <= mckCnt_ff;
                period_ff <= periodCnt_ff;
                ratioOk_ff <= (seqIdx + 11'(isI2s)) == frameLen;
            end
        end else begin
            if (mckRise && mckCnt_ff != BIT_SAT) begin
                mckCnt_ff <= mckCnt_ff + 11'h001;
            end
            if (periodCnt_ff != PERIOD_SAT) begin
                periodCnt_ff <= periodCnt_ff + 16'h0001;
            end
        end
    end
    // High-performance detect: rates from measured master clock and frame period
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            highPerfMode <= 1'b0;
        end else begin
            highPerfMode <= (syncState_ff == SYNC_RUN) && !silent
                && (frameBits_ff == 11'(HP_BITS_BASE << ctrl_ff.mode))
                && (((ctrl_ff.speed == SPEED_001) && (mckPerFrame_ff == MCK_PER_48)
                && (period_ff > FRAME48_CYC - FRAME_TOL_CYC)
                && (period_ff < FRAME48_CYC + FRAME_TOL_CYC))
                || (((ctrl_ff.speed == SPEED_001) || (ctrl_ff.speed == SPEED_010))
                && (ctrl_ff.mode != MODE_512) && (mckPerFrame_ff == MCK_PER_96)
                && (period_ff > FRAME96_CYC - FRAME_TOL_CYC)
                && (period_ff < FRAME96_CYC + FRAME_TOL_CYC)));
        end
    end
    // Place the received sample left aligned in 32 bits
    function automatic logic [31:0] alignSample(input logic [31:0] w, input logic [2:0] f);
        case (f)
            FMT_MSB24, FMT_I2S24: alignSample = {w[31:8], 8'h00};
            FMT_LSB24: alignSample = {w[23:0], 8'h00};
            FMT_LSB32, FMT_MSB32, FMT_I2S32: alignSample = w;
            default: alignSample = 32'h0000_0000;
        endcase
    endfunction
    // Pair selection per DAC; a pair is an even left slot and the odd right one
    for (genvar k = 0; k < 4; k++) begin : g_dac
        logic [2:0] pairIdx;
        assign pairIdx = isFrameMode ? 3'(k) + ctrl_ff.rot
            : {1'b0, 2'(k) + ctrl_ff.rot[1:0]};
        assign nxt_dacOut[k].left = silent ? 32'h0000_0000
            : alignSample(slotMem[{pairIdx, 1'b0}], ctrl_ff.fmt);
        assign nxt_dacOut[k].right = silent ? 32'h0000_0000
            : alignSample(slotMem[{pairIdx, 1'b1}], ctrl_ff.fmt);
    end
    // Outputs change two cycles after the frame edge, in the cycle the strobe marks them
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            edgeDly_ff <= 1'b0;
            sampleStrobe <= 1'b0;
            dacOut <= '0;
        end else begin
            edgeDly_ff <= frameEdge && (syncState_ff == SYNC_RUN);
            sampleStrobe <= edgeDly_ff;
            if (edgeDly_ff) begin
                dacOut <= nxt_dacOut;
            end
        end
    end

    // APB: zero wait states, error on unmapped offsets
    assign addrMapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS)
        || (paddr == ADDR_BITS) || (paddr == ADDR_MEAS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addrMapped;

    // Control register, byte lanes honoured; writes mid-stream are not blocked
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= CTRL_RESET;
        end else if (psel && penable && pwrite && (paddr == ADDR_CTRL)) begin
            if (pstrb[0]) begin
                ctrl_ff[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                ctrl_ff[10:8] <= pwdata[10:8];
            end
        end
    end

    // Read data is latched in the setup cycle so it is a flop in the access phase
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                ADDR_CTRL: prdata <= {21'h000000, ctrl_ff};
                ADDR_STATUS: prdata <= {28'h0000000, highPerfMode, silent, ratioOk_ff,
                    syncState_ff == SYNC_RUN};
                ADDR_BITS: prdata <= {21'h000000, frameBits_ff};
                ADDR_MEAS: prdata <= {period_ff, 5'h00, mckPerFrame_ff};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    a_ratio_256: assert property (
        frameEdge && syncState_ff == SYNC_RUN && ctrl_ff.mode == MODE_256
        && (seqIdx + 11'(isI2s)) == FRAME_BITS_256 |=> ratioOk_ff)
        else $error("256-fs frame of 256 bits not flagged good");
    a_ratio_512: assert property (
        frameEdge && syncState_ff == SYNC_RUN && ctrl_ff.mode == MODE_512
        && (seqIdx + 11'(isI2s)) != FRAME_BITS_512 |=> !ratioOk_ff)
        else $error("512-fs frame of wrong length flagged good");
    a_i2s_delay: assert property (
        frameEdge && isI2s |=> bitCnt_ff == BIT_PRE && $past(lrLast_ff) && !$past(pinSync_ff[1]))
        else $error("I2S frame did not start one bit late on falling edge");
    a_msb_start: assert property (
        frameEdge && !isI2s |=> bitCnt_ff == 11'h000 && $past(pinSync_ff[1]))
        else $error("justified frame did not start on rising edge");
    a_slot_first: assert property (
        bclkRise && isFrameMode && syncState_ff == SYNC_RUN && seqIdx == 11'h01F
        |=> slotMem[0] == $past(wordA))
        else $error("first slot not stored after 32 bits");
    a_silence_bad: assert property (
        edgeDly_ff && silent |=> dacOut == '0 && sampleStrobe)
        else $error("unsupported format did not give silence");
    a_rotation_first: assert property (
        edgeDly_ff && !silent && ctrl_ff.fmt == FMT_MSB32
        |=> dacOut[0].left == $past(slotMem[{ctrl_ff.rot, 1'b0}]))
        else $error("DAC1 did not play the rotated pair");
    a_rotation_second: assert property (
        edgeDly_ff && !silent && ctrl_ff.fmt == FMT_LSB32
        |=> dacOut[1].right == $past(slotMem[{3'(ctrl_ff.rot + 3'h1), 1'b1}]))
        else $error("DAC2 right did not play the rotated pair");
    a_lsb24_align: assert property (
        edgeDly_ff && !silent && ctrl_ff.fmt == FMT_LSB24 |=> dacOut[2].left[7:0] == 8'h00)
        else $error("24-bit sample not left aligned");
    a_perf_speed: assert property (
        highPerfMode |-> ctrl_ff.speed == SPEED_001 || ctrl_ff.speed == SPEED_010)
        else $error("high-performance mode with wrong speed range");
    a_perf96_mode: assert property (
        highPerfMode && mckPerFrame_ff == MCK_PER_96 |-> ctrl_ff.mode != MODE_512)
        else $error("96 kHz high-performance mode in 512-fs mode");
endmodule

// >>> audio_source_model.sv
// Behavioural serial audio source that feeds the frame-mode receiver
`timescale 1ns/10ps
module audio_source_model (
    // Stream control from the bench
    input wire logic run,
    input wire logic [1:0] mode,
    input wire logic [2:0] fmt,
    // Serial pins towards the receiver
    output logic bitClk,
    output logic frameClk,
    output logic [3:0] dataOut,
    output logic masterClk
);
    int nBits; // Bit clocks in the current frame
    int pos; // Stream position carried by this bit
    logic i2s; // Current frame uses the delayed, falling-edge layout
    logic [31:0] w0; // Slot word on line 1
    logic [31:0] w1; // Slot word on line 2

    // Line and slot number in the top byte so any misrouting shows
    function automatic logic [31:0] slotWord(input int line, input int idx);
        return {4'(line), 4'(idx), 8'hC3, 8'h5A, ~8'(idx * 17 + line)};
    endfunction

    // Master clock near 12.288 MHz, free running
    initial begin
        masterClk = 1'b0;
        forever #40.69 masterClk = ~masterClk;
    end

    // Frame generator; settings are taken only at a frame start
    initial begin
        bitClk = 1'b0;
        frameClk = 1'b0;
        dataOut = 4'h0;
        forever begin
            if (run !== 1'b1) begin
                // Bit clock parks low; released lines never hold a stale level
                bitClk = 1'b0;
                dataOut = ~dataOut;
                #160;
            end else begin
                nBits = (mode == 2'h3) ? 512 : 256;
                i2s = (fmt[1:0] == 2'b11);
                for (int b = 0; b < nBits; b++) begin
                    // I2S data trails the frame edge by one bit
                    pos = i2s ? (b + nBits - 1) % nBits : b;
                    frameClk = (b < nBits / 2) ^ i2s;
                    // 32-bit slots, enough for every sample length
                    w0 = slotWord(0, pos / 32);
                    w1 = slotWord(1, pos / 32);
                    // MSB first, changed while the bit clock is low; lines 3-4 toggle
                    dataOut = {~dataOut[3:2], w1[31 - pos % 32], w0[31 - pos % 32]};
                    #80 bitClk = 1'b1;
                    #80 bitClk = 1'b0;
                end
            end
        end
    end
endmodule

// >>> tdm_audio_rx_test.sv
// Self-checking bench for the frame-mode audio receiver
`timescale 1ns/10ps
module tdm_audio_rx_test;
    import tdm_rx_pkg::*;
    logic mclk = 1'b0; // System clock
    logic resetn = 1'b0; // Active-low reset
    logic psel = 1'b0; // APB select
    logic penable = 1'b0; // APB access phase
    logic pwrite = 1'b0; // APB direction
    logic [APB_AW-1:0] paddr = 12'h000; // APB byte address
    logic [31:0] pwdata = 32'h0; // APB write data
    logic [31:0] prdata; // APB read data
    logic pready; // APB ready
    logic pslverr; // APB error
    logic bitClk; // Serial bit clock
    logic frameClk; // Frame clock
    logic masterClk; // Audio master clock
    logic [3:0] dataIn; // Serial data lines
    dacPair_s [3:0] dacOut; // Four stereo DAC samples
    logic sampleStrobe; // New samples pulse
    logic highPerfMode; // Performance flag
    logic run = 1'b0; // Source streaming
    logic [1:0] srcMode = 2'h2; // Source frame length
    logic [2:0] srcFmt = 3'h2; // Source layout
    int miscompares = 0; // Mismatches seen
    int testsRun = 0; // Comparisons made
    int cycles = 0; // Watchdog count
    int q; // Expected input pair
    logic [31:0] rd; // Last read data
    logic err; // Last error flag
    ctrl_s cw; // Control word being tried
    // Rows: frame mode, format, strobes to wait, rotation
    int cfg[10][4] = '{'{2,2,2,0}, '{2,4,2,1}, '{2,5,2,2}, '{2,6,2,3}, '{2,3,3,4},
        '{2,7,1,5}, '{2,7,1,6}, '{2,0,3,0}, '{3,6,2,7}, '{3,1,1,0}};

    tdm_audio_rx dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serialBitClock(bitClk),
        .frameSyncClock(frameClk), .serialDataInput(dataIn), .audioMasterClock(masterClk),
        .dacOut(dacOut), .sampleStrobe(sampleStrobe), .highPerfMode(highPerfMode));
    audio_source_model src (.run(run), .mode(srcMode), .fmt(srcFmt), .bitClk(bitClk),
        .frameClk(frameClk), .dataOut(dataIn), .masterClk(masterClk));

    // 100 MHz system clock
    always #5 mclk = ~mclk;

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        // Ends when pready is seen high; only the watchdog may end it if pready never rises
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Skip strobes; early ones may mix old and new settings
    task automatic waitStrobes(input int n);
        for (int i = 0; i < n; i++) begin
            do begin
                @(posedge mclk);
            end while (sampleStrobe !== 1'b1);
        end
    endtask

    // Expected sample of stored slot s; 256-fs takes slots 8-15 from line 2
    function automatic logic [31:0] expWord(input int s, input int m, input int f);
        logic [31:0] w;
        w = (m == 2 && s > 7) ? src.slotWord(1, s - 8) : src.slotWord(0, s);
        if (f < 2) return 32'h0;
        if (f == 4) return {w[23:0], 8'h00};
        if (f < 4) return {w[31:8], 8'h00};
        return w;
    endfunction

    // Counts, verdict and end of run
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog against a hung wait; the scenarios need about 86k cycles of frames
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 100000) begin
            miscompares++;
            results();
        end
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge mclk);
        check(32'(sampleStrobe), 32'h0);
        check(32'(|dacOut), 32'h0);
        resetn <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'(CTRL_RESET));
        apb(1'b0, 12'h010, 32'h0);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        foreach (cfg[i]) begin
            cw = '{speed: SPEED_001, rot: 3'(cfg[i][3]), fmt: 3'(cfg[i][1]),
                mode: 2'(cfg[i][0])};
            apb(1'b1, ADDR_CTRL, 32'(cw));
            srcMode <= cw.mode;
            srcFmt <= cw.fmt;
            run <= 1'b1;
            waitStrobes(cfg[i][2]);
            for (int k = 0; k < 4; k++) begin
                q = (k + cfg[i][3]) % 8;
                check(dacOut[k].left, expWord(2 * q, cfg[i][0], cfg[i][1]));
                check(dacOut[k].right, expWord(2 * q + 1, cfg[i][0], cfg[i][1]));
            end
            apb(1'b0, ADDR_CTRL, 32'h0);
            check(rd, 32'(cw));
            apb(1'b0, ADDR_BITS, 32'h0);
            check(rd, (cfg[i][0] == 3) ? 32'h200 : 32'h100);
            apb(1'b0, ADDR_STATUS, 32'h0);
            check(32'(rd[2]), 32'(cfg[i][1] < 2));
        end
        // Last frame was 512 bits of 160 ns: 8192 cycles, about 1006.6 master clocks
        apb(1'b0, ADDR_MEAS, 32'h0);
        check(32'(rd[31:16] > 16'h1FFE && rd[31:16] < 16'h2002), 32'h1);
        check(32'(rd[10:0] > 11'h3EC && rd[10:0] < 11'h3F1), 32'h1);
        check(32'(highPerfMode), 32'h0);
        results();
    end
endmodule
